// ---- hdl/motor_drive_pkg.sv ----
// Constants for the per-axis motor drive output stage.
// Assumes a 100 MHz controller clock and a 32-bit AXI4-Lite register bus.
package motor_drive_pkg;
   localparam int unsigned CLOCK_FREQ_HZ   = 100_000_000;
   localparam int unsigned PWM_INV_FREQ_HZ = 25_000;
   localparam int unsigned PWM_MAG_FREQ_HZ = 50_000;
   localparam int unsigned INV_MIN_PERMILLE = 2;
   localparam int unsigned MAG_MAX_PERMILLE = 996;
   localparam int unsigned INV_PERIOD_INT   = CLOCK_FREQ_HZ / PWM_INV_FREQ_HZ;
   localparam int unsigned MAG_PERIOD_INT   = CLOCK_FREQ_HZ / PWM_MAG_FREQ_HZ;
   localparam logic [11:0] INV_PERIOD   = 12'(INV_PERIOD_INT);
   localparam logic [11:0] MAG_PERIOD   = 12'(MAG_PERIOD_INT);
   localparam logic [11:0] INV_MIN_HIGH = 12'(INV_PERIOD_INT * INV_MIN_PERMILLE / 1000);
   localparam logic [11:0] INV_MID_HIGH = 12'(INV_PERIOD_INT / 2);
   localparam logic [11:0] INV_SPAN     = 12'(INV_PERIOD_INT / 2 - INV_PERIOD_INT
                                          * INV_MIN_PERMILLE / 1000);
   localparam logic [11:0] MAG_SPAN     = 12'(MAG_PERIOD_INT * MAG_MAX_PERMILLE / 1000);
   localparam int          SCALE_SHIFT  = 15;
   localparam logic signed [31:0] SCALE_ROUND = 32'sh0000_4000;

   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_SERVO_CMD = 8'h04;
   localparam logic [7:0] ADDR_IDLE      = 8'h08;
   localparam logic [7:0] ADDR_STEP_HALF = 8'h0c;
   localparam logic [7:0] ADDR_FAULT_THR = 8'h10;
   localparam logic [7:0] ADDR_SET_BIT   = 8'h14;
   localparam logic [7:0] ADDR_CLR_BIT   = 8'h18;
   localparam logic [7:0] ADDR_PORT      = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h24;
   localparam logic [7:0] ADDR_STATE     = 8'h28;

   localparam int CTRL_AMP_ON     = 0;
   localparam int CTRL_MOTOR_OFF  = 1;
   localparam int CTRL_STEPPER    = 2;
   localparam int CTRL_STEP_HIGH  = 3;
   localparam int CTRL_STEP_RUN   = 4;
   localparam int CTRL_DIRECTION  = 5;
   localparam int CTRL_DRIVE      = 6;
   localparam int CTRL_WIDTH      = 7;

   localparam int IRQ_SAMPLE = 0;
   localparam int IRQ_FAULT  = 1;
   localparam int IRQ_STEP   = 2;
   localparam int IRQ_WIDTH  = 3;

   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h02;
   localparam logic [15:0] STEP_HALF_RESET = 16'h0064;
   localparam logic [15:0] FAULT_THR_RESET = 16'h7fff;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ---- hdl/motor_drive_output_stage.sv ----
// One axis of motor drive output: command level, amp enable, PWM or step, sign, error, GPIO.
// Assumes sampleTick and posError come from the servo loop on the same clock;
// the sign-magnitude jumper is an asynchronous pin.
`timescale 1ns/1ps
`default_nettype none

module motor_drive_output_stage
   import motor_drive_pkg::*;
(
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               rst,
   // AXI4-Lite slave
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // Servo loop
   input  wire logic               sampleTick,
   input  wire logic signed [15:0] posError,
   // Amplifier side
   input  wire logic               signMagnitudeJumper,
   output logic [15:0]             motorCommand,
   output logic                    ampEnableN,
   output logic                    pwmStepOut,
   output logic                    pwmStepOe,
   output logic                    signOut,
   output logic                    errorOutN,
   output logic [7:0]              generalOut,
   output logic                    irq
);
   typedef struct packed {
      logic                  awHave;
      logic [7:0]            awAddr;
      logic                  wHave;
      logic [31:0]           wData;
      logic [3:0]            wStrb;
      logic                  bValid;
      logic [1:0]            bResp;
      logic                  rValid;
      logic [31:0]           rData;
      logic [1:0]            rResp;
      logic [CTRL_WIDTH-1:0] ctrl;
      logic [15:0]           servoCmd;
      logic [15:0]           idleLevel;
      logic [15:0]           stepHalf;
      logic [15:0]           faultThr;
      logic [7:0]            gpio;
      logic [IRQ_WIDTH-1:0]  irqStatus;
      logic [IRQ_WIDTH-1:0]  irqMask;
      logic [15:0]           motorCmd;
      logic [11:0]           pwmCnt;
      logic [15:0]           stepCnt;
      logic                  stepPhase;
      logic                  pwmStepOut;
      logic                  signOut;
      logic                  faultN;
      logic                  jumperMeta;
      logic                  jumper;
      logic                  jumperLast;
   } state_type;

   state_type state_q;
   state_type state_d;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [16:0] magnitude(input logic signed [15:0] v);
      logic signed [16:0] w;
      w = 17'(v);
      return (w < 0) ? 17'(-w) : 17'(w);
   endfunction

   // Rounded v * span / 32768, keeps the duty a straight line in the command
   function automatic logic signed [12:0] scale(input logic signed [17:0] v,
                                                input logic [11:0]        span);
      logic signed [31:0] p;
      p = 32'(v) * $signed({20'h0, span}) + SCALE_ROUND;
      return 13'(p >>> SCALE_SHIFT);
   endfunction

   logic        cmdNeg;
   logic [11:0] pwmPeriod;
   logic [11:0] highCnt;
   logic        faultNow;
   logic        doWrite;
   logic [31:0] wMerged;
   logic [IRQ_WIDTH-1:0] irqEvents;

   always_comb begin
      state_d = state_q;
      cmdNeg = state_q.motorCmd[15];
      wMerged = 32'h0;
      irqEvents = '0;

      state_d.jumperMeta = signMagnitudeJumper;
      state_d.jumper = state_q.jumperMeta;
      state_d.jumperLast = state_q.jumper;

      // Command refresh on the sample tick only
      if (sampleTick) begin
         state_d.motorCmd = state_q.ctrl[CTRL_MOTOR_OFF] ? state_q.idleLevel
                                                        : state_q.servoCmd;
         irqEvents[IRQ_SAMPLE] = 1'b1;
      end

      // PWM carrier
      pwmPeriod = state_q.jumper ? MAG_PERIOD : INV_PERIOD;
      if (state_q.jumper) begin
         highCnt = 12'(scale($signed({1'b0, magnitude(state_q.motorCmd)}), MAG_SPAN));
      end else begin
         highCnt = 12'(scale(18'(signed'(state_q.motorCmd)), INV_SPAN)) + INV_MID_HIGH;
      end
      state_d.pwmCnt = (state_q.pwmCnt >= pwmPeriod - 12'h001) ? 12'h000
                                                              : state_q.pwmCnt + 12'h001;

      // Step train, each half period stepHalf cycles
      if (state_q.ctrl[CTRL_STEPPER] && state_q.ctrl[CTRL_STEP_RUN]) begin
         if (state_q.stepCnt >= state_q.stepHalf - 16'h0001) begin
            state_d.stepCnt = 16'h0000;
            state_d.stepPhase = ~state_q.stepPhase;
            irqEvents[IRQ_STEP] = state_q.stepPhase;
         end else begin
            state_d.stepCnt = state_q.stepCnt + 16'h0001;
         end
      end else begin
         state_d.stepCnt = 16'h0000;
         state_d.stepPhase = 1'b0;
      end

      if (state_q.ctrl[CTRL_STEPPER]) begin
         state_d.pwmStepOut = state_q.ctrl[CTRL_STEP_HIGH] ? state_q.stepPhase
                                                          : ~state_q.stepPhase;
         state_d.signOut = state_q.ctrl[CTRL_DIRECTION];
      end else begin
         state_d.pwmStepOut = state_q.pwmCnt < highCnt;
         state_d.signOut = cmdNeg;
      end

      faultNow = magnitude(posError) > {1'b0, state_q.faultThr};
      state_d.faultN = ~faultNow;
      irqEvents[IRQ_FAULT] = faultNow && state_q.faultN;

      // Bus: address and data taken in either order
      if (s_axi_awvalid && !state_q.awHave) begin
         state_d.awHave = 1'b1;
         state_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_q.wHave) begin
         state_d.wHave = 1'b1;
         state_d.wData = s_axi_wdata;
         state_d.wStrb = s_axi_wstrb;
      end
      if (state_q.bValid && s_axi_bready) begin
         state_d.bValid = 1'b0;
      end
      doWrite = state_q.awHave && state_q.wHave && !state_q.bValid;
      state_d.irqStatus = state_q.irqStatus;
      if (doWrite) begin
         state_d.awHave = 1'b0;
         state_d.wHave = 1'b0;
         state_d.bValid = 1'b1;
         state_d.bResp = RESP_OKAY;
         unique case (state_q.awAddr)
            ADDR_CTRL: begin
               wMerged = mergeBytes(32'(state_q.ctrl), state_q.wData, state_q.wStrb);
               state_d.ctrl = wMerged[CTRL_WIDTH-1:0];
            end
            ADDR_SERVO_CMD: begin
               wMerged = mergeBytes(32'(state_q.servoCmd), state_q.wData, state_q.wStrb);
               state_d.servoCmd = wMerged[15:0];
            end
            ADDR_IDLE: begin
               wMerged = mergeBytes(32'(state_q.idleLevel), state_q.wData, state_q.wStrb);
               state_d.idleLevel = wMerged[15:0];
            end
            ADDR_STEP_HALF: begin
               wMerged = mergeBytes(32'(state_q.stepHalf), state_q.wData, state_q.wStrb);
               state_d.stepHalf = wMerged[15:0];
            end
            ADDR_FAULT_THR: begin
               wMerged = mergeBytes(32'(state_q.faultThr), state_q.wData, state_q.wStrb);
               state_d.faultThr = wMerged[15:0];
            end
            ADDR_SET_BIT: begin
               if (state_q.wStrb[0]) begin
                  state_d.gpio[state_q.wData[2:0]] = 1'b1;
               end
            end
            ADDR_CLR_BIT: begin
               if (state_q.wStrb[0]) begin
                  state_d.gpio[state_q.wData[2:0]] = 1'b0;
               end
            end
            ADDR_PORT: begin
               if (state_q.wStrb[0]) begin
                  state_d.gpio = state_q.wData[7:0];
               end
            end
            ADDR_IRQ_STAT: begin
               if (state_q.wStrb[0]) begin
                  state_d.irqStatus = state_q.irqStatus & ~state_q.wData[IRQ_WIDTH-1:0];
               end
            end
            ADDR_IRQ_MASK: begin
               wMerged = mergeBytes(32'(state_q.irqMask), state_q.wData, state_q.wStrb);
               state_d.irqMask = wMerged[IRQ_WIDTH-1:0];
            end
            ADDR_STATE: begin
               state_d.bResp = RESP_OKAY;
            end
            default: begin
               state_d.bResp = RESP_SLVERR;
            end
         endcase
      end
      // A new event outweighs a clear in the same cycle
      state_d.irqStatus = state_d.irqStatus | irqEvents;

      if (state_q.rValid && s_axi_rready) begin
         state_d.rValid = 1'b0;
      end
      if (s_axi_arvalid && !state_q.rValid) begin
         state_d.rValid = 1'b1;
         state_d.rResp = RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_CTRL:      state_d.rData = 32'(state_q.ctrl);
            ADDR_SERVO_CMD: state_d.rData = 32'(state_q.servoCmd);
            ADDR_IDLE:      state_d.rData = 32'(state_q.idleLevel);
            ADDR_STEP_HALF: state_d.rData = 32'(state_q.stepHalf);
            ADDR_FAULT_THR: state_d.rData = 32'(state_q.faultThr);
            ADDR_SET_BIT:   state_d.rData = 32'h0;
            ADDR_CLR_BIT:   state_d.rData = 32'h0;
            ADDR_PORT:      state_d.rData = 32'(state_q.gpio);
            ADDR_IRQ_STAT:  state_d.rData = 32'(state_q.irqStatus);
            ADDR_IRQ_MASK:  state_d.rData = 32'(state_q.irqMask);
            ADDR_STATE:     state_d.rData = {13'h0, state_q.jumper, ~state_q.faultN,
                                             state_q.pwmStepOut, state_q.motorCmd};
            default: begin
               state_d.rData = 32'h0;
               state_d.rResp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= '0;
         state_q.ctrl <= CTRL_RESET;
         state_q.stepHalf <= STEP_HALF_RESET;
         state_q.faultThr <= FAULT_THR_RESET;
         state_q.faultN <= 1'b1;
      end else begin
         state_q <= state_d;
      end
   end

   assign s_axi_awready = !state_q.awHave;
   assign s_axi_wready  = !state_q.wHave;
   assign s_axi_bvalid  = state_q.bValid;
   assign s_axi_bresp   = state_q.bResp;
   assign s_axi_arready = !state_q.rValid;
   assign s_axi_rvalid  = state_q.rValid;
   assign s_axi_rdata   = state_q.rData;
   assign s_axi_rresp   = state_q.rResp;
   assign motorCommand  = state_q.motorCmd;
   assign ampEnableN    = ~state_q.ctrl[CTRL_AMP_ON];
   assign pwmStepOut    = state_q.pwmStepOut;
   // Jumper or the CTRL_DRIVE bit decides drive or float; jumper a cycle late so no stale carrier level escapes
   assign pwmStepOe     = state_q.ctrl[CTRL_DRIVE] | state_q.jumperLast;
   assign signOut       = state_q.signOut;
   assign errorOutN     = state_q.faultN;
   assign generalOut    = state_q.gpio;
   assign irq           = |(state_q.irqStatus & state_q.irqMask);

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   sequence cmdRefresh;
      sampleTick && !state_q.ctrl[CTRL_MOTOR_OFF];
   endsequence

   chk_cmd_hold: assert property (!sampleTick |=> $stable(motorCommand))
      else $error("motor command moved without a sample tick");
   chk_cmd_refresh: assert property (cmdRefresh |=> motorCommand == $past(state_q.servoCmd))
      else $error("servo command not applied on tick");
   chk_idle_level: assert property (sampleTick && state_q.ctrl[CTRL_MOTOR_OFF]
                                    |=> motorCommand == $past(state_q.idleLevel))
      else $error("idle level not applied in motor off");
   chk_amp_polarity: assert property ($rose(state_q.ctrl[CTRL_AMP_ON]) |-> !ampEnableN)
      else $error("amp enable not low when enabled");
   chk_inv_endpoints: assert property (!state_q.jumper |-> highCnt >= INV_MIN_HIGH
                                       && highCnt <= INV_PERIOD - INV_MIN_HIGH)
      else $error("inverter duty outside endpoints");
   chk_inv_period: assert property (!state_q.jumper && state_q.pwmCnt == INV_PERIOD - 12'h001
                                    |=> state_q.pwmCnt == 12'h000)
      else $error("inverter carrier period wrong");
   chk_mag_zero: assert property (state_q.jumper && state_q.motorCmd == 16'h0000
                                  |-> highCnt == 12'h000)
      else $error("sign magnitude duty not zero at zero");
   chk_mag_period: assert property (state_q.jumper && state_q.pwmCnt == MAG_PERIOD - 12'h001
                                    |=> state_q.pwmCnt == 12'h000)
      else $error("sign magnitude period wrong");
   chk_step_polarity: assert property (state_q.ctrl[CTRL_STEPPER] && state_q.ctrl[CTRL_STEP_HIGH]
                                       |=> pwmStepOut == $past(state_q.stepPhase))
      else $error("step level does not follow phase");
   chk_sign_servo: assert property (!state_q.ctrl[CTRL_STEPPER]
                                    |=> signOut == $past(state_q.motorCmd[15]))
      else $error("sign output not command polarity");
   chk_fault_out: assert property (magnitude(posError) > {1'b0, state_q.faultThr}
                                   |=> !errorOutN)
      else $error("error output not low on fault");
   chk_port_write: assert property (doWrite && state_q.awAddr == ADDR_PORT && state_q.wStrb[0]
                                    |=> generalOut == $past(state_q.wData[7:0]))
      else $error("port write not loaded");
   chk_bit_set: assert property (doWrite && state_q.awAddr == ADDR_SET_BIT && state_q.wStrb[0]
                                 |=> generalOut[$past(state_q.wData[2:0])])
      else $error("set bit not applied");
endmodule

`default_nettype wire

// ---- bench/amp_model.sv ----
// Amplifier model: watches the PWM/step input and reports its last whole period.
// Assumes the bench resolves the pin with the amplifier's input pull-up.
`timescale 1ns/1ps
`default_nettype none
module amp_model (
   // Clock
   input  wire logic  clock,
   // Resolved PWM/step pin
   input  wire logic  pinLevel,
   // Measurements, in clock cycles
   output logic [15:0] highCycles,
   output logic [15:0] periodCycles
);
   logic        lastLevel = 1'b1;
   logic [15:0] sinceRise = 16'h0000;

   // The first period after start is partial; callers wait two periods
   always_ff @(posedge clock) begin
      lastLevel <= pinLevel;
      if (pinLevel && !lastLevel) begin
         periodCycles <= sinceRise;
         sinceRise    <= 16'h0001;
      end else begin
         sinceRise <= sinceRise + 16'h0001;
      end
      if (!pinLevel && lastLevel) begin
         highCycles <= sinceRise;
      end
   end
endmodule
`default_nettype wire

// ---- bench/motor_drive_output_stage_tb.sv ----
// Self-checking bench for the motor drive output stage.
// Assumes the package, the design and amp_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module motor_drive_output_stage_tb
   import motor_drive_pkg::*;
;
   logic               clock = 1'b0;
   logic               rst = 1'b1;
   logic [7:0]         s_axi_awaddr = 8'h00;
   logic [7:0]         s_axi_araddr = 8'h00;
   logic [31:0]        s_axi_wdata = 32'h0;
   logic [3:0]         s_axi_wstrb = 4'hf;
   logic               s_axi_awvalid = 1'b0;
   logic               s_axi_wvalid = 1'b0;
   logic               s_axi_bready = 1'b0;
   logic               s_axi_arvalid = 1'b0;
   logic               s_axi_rready = 1'b0;
   logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]         s_axi_bresp, s_axi_rresp, lastResp;
   logic [31:0]        s_axi_rdata, lastData;
   logic               sampleTick = 1'b0;
   logic               signMagnitudeJumper = 1'b0;
   logic signed [15:0] posError = 16'sh0000;
   logic [15:0]        motorCommand, highCycles, periodCycles;
   logic               ampEnableN, pwmStepOut, pwmStepOe, signOut, errorOutN, irq;
   logic [7:0]         generalOut;
   // Amplifier input has a pull-up, so a floating pin reads high
   wire                pinLevel = pwmStepOe ? pwmStepOut : 1'b1;
   int                 failures = 0;
   int                 comparisons = 0;

   always #5 clock = ~clock;

   motor_drive_output_stage i_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .sampleTick, .posError, .signMagnitudeJumper, .motorCommand, .ampEnableN,
      .pwmStepOut, .pwmStepOe, .signOut, .errorOutN, .generalOut, .irq);
   amp_model i_amp (.clock, .pinLevel, .highCycles, .periodCycles);

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Ready is sampled at the falling edge, where it equals its value at the next rise
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
      logic awT, wT;
      awT = 1'b0;
      wT = 1'b0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(awT && wT)) begin
         @(negedge clock);
         awT = awT || s_axi_awready;
         wT = wT || s_axi_wready;
         @(posedge clock);
         if (awT) s_axi_awvalid <= 1'b0;
         if (wT) s_axi_wvalid <= 1'b0;
      end
      do @(negedge clock); while (!s_axi_bvalid);
      lastResp = s_axi_bresp;
      @(posedge clock);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clock); while (!s_axi_arready);
      @(posedge clock);
      s_axi_arvalid <= 1'b0;
      do @(negedge clock); while (!s_axi_rvalid);
      lastData = s_axi_rdata;
      lastResp = s_axi_rresp;
      @(posedge clock);
      s_axi_rready <= 1'b0;
   endtask

   task automatic tick();
      @(posedge clock);
      sampleTick <= 1'b1;
      @(posedge clock);
      sampleTick <= 1'b0;
   endtask

   // Two whole periods after the tick the model holds a period of the new duty only
   task automatic measure(input logic [15:0] cmd, input logic [15:0] high, input logic [11:0] per);
      axiWrite(ADDR_SERVO_CMD, {16'h0000, cmd});
      tick();
      repeat (2 * int'(per) + 10) @(negedge clock);
      check("high cycles", high, highCycles);
      check("period cycles", {4'h0, per}, periodCycles);
      check("sign", cmd[15], signOut);
   endtask

   task automatic testReset();
      repeat (3) @(negedge clock);
      check("ampEnableN", 1'b1, ampEnableN);
      check("pwmStepOe", 1'b0, pwmStepOe);
      axiRead(ADDR_CTRL);
      check("ctrl", {25'h0, CTRL_RESET}, lastData);
      axiWrite(ADDR_CTRL, 32'h41);
      @(negedge clock);
      check("ampEnableN", 1'b0, ampEnableN);
   endtask

   task automatic testCommand();
      axiWrite(ADDR_CTRL, 32'h43);
      axiWrite(ADDR_IDLE, 32'h1234);
      axiWrite(ADDR_SERVO_CMD, 32'h5678);
      tick();
      @(negedge clock);
      check("idle command", 16'h1234, motorCommand);
      axiWrite(ADDR_CTRL, 32'h41);
      repeat (5) @(negedge clock);
      check("held command", 16'h1234, motorCommand);
      tick();
      @(negedge clock);
      check("servo command", 16'h5678, motorCommand);
   endtask

   // Inverter: 4000-cycle period, 8 / 2000 / 3992 high at the ends and centre
   task automatic testInverter();
      measure(16'h8000, 16'h0008, INV_PERIOD);
      measure(16'h0000, 16'h07d0, INV_PERIOD);
      measure(16'h7fff, 16'h0f98, INV_PERIOD);
      measure(16'h4000, 16'h0bb4, INV_PERIOD);
   endtask

   task automatic testOutputs();
      axiWrite(ADDR_PORT, 32'ha5);
      check("port write", 8'ha5, generalOut);
      axiWrite(ADDR_SET_BIT, 32'h1);
      check("set bit", 8'ha7, generalOut);
      axiWrite(ADDR_CLR_BIT, 32'h7);
      check("clear bit", 8'h27, generalOut);
      axiRead(ADDR_PORT);
      check("port read", 32'h27, lastData);
      axiWrite(8'h30, 32'hff);
      check("unmapped bresp", RESP_SLVERR, lastResp);
      axiRead(8'h30);
      check("unmapped rresp", RESP_SLVERR, lastResp);
      check("outputs kept", 8'h27, generalOut);
   endtask

   task automatic testSignMagnitude();
      int highSeen;
      highSeen = 0;
      @(posedge clock);
      signMagnitudeJumper <= 1'b1;
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(negedge clock);
      check("pin drive", 1'b1, pwmStepOe);
      check("pin level", 1'b0, pwmStepOut);
      axiWrite(ADDR_CTRL, 32'h01);
      measure(16'h8000, 16'h07c8, MAG_PERIOD);
      measure(16'h4000, 16'h03e4, MAG_PERIOD);
      axiWrite(ADDR_SERVO_CMD, 32'h0);
      tick();
      // The first pin level after the tick still belongs to the old command
      @(negedge clock);
      repeat (int'(MAG_PERIOD)) begin
         @(negedge clock);
         highSeen += int'(pinLevel);
      end
      check("zero duty", 32'h0, highSeen);
   endtask

   // Half period of 10 cycles; the inactive level shows as the idle level of each polarity
   task automatic testStepper();
      axiWrite(ADDR_STEP_HALF, 32'h0a);
      axiWrite(ADDR_CTRL, 32'h0d);
      repeat (3) @(negedge clock);
      check("idle step high", 1'b0, pinLevel);
      axiWrite(ADDR_CTRL, 32'h3d);
      repeat (60) @(negedge clock);
      check("step high", 16'h000a, highCycles);
      check("step period", 16'h0014, periodCycles);
      check("direction", 1'b1, signOut);
      axiWrite(ADDR_CTRL, 32'h05);
      repeat (3) @(negedge clock);
      check("idle step low", 1'b1, pinLevel);
      axiWrite(ADDR_CTRL, 32'h15);
      repeat (60) @(negedge clock);
      check("step low", 16'h000a, periodCycles - highCycles);
      check("direction", 1'b0, signOut);
   endtask

   task automatic testFault();
      axiWrite(ADDR_CTRL, 32'h01);
      axiWrite(ADDR_FAULT_THR, 32'h64);
      axiWrite(ADDR_IRQ_STAT, 32'h7);
      axiWrite(ADDR_IRQ_MASK, 32'h2);
      check("irq masked", 1'b0, irq);
      posError <= 16'sh0065;
      repeat (2) @(negedge clock);
      check("errorOutN", 1'b0, errorOutN);
      check("irq fault", 1'b1, irq);
      @(posedge clock);
      posError <= 16'shff9b;
      repeat (2) @(negedge clock);
      check("errorOutN", 1'b0, errorOutN);
      @(posedge clock);
      posError <= 16'sh0064;
      repeat (2) @(negedge clock);
      check("errorOutN", 1'b1, errorOutN);
      axiWrite(ADDR_IRQ_STAT, 32'h2);
      check("irq cleared", 1'b0, irq);
      axiWrite(ADDR_IRQ_MASK, 32'h1);
      tick();
      @(negedge clock);
      check("irq tick", 1'b1, irq);
   endtask

   task automatic print_verdict();
      if (failures == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clock);
      failures++;
      print_verdict();
   end

   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      testReset();
      testCommand();
      testInverter();
      testOutputs();
      testSignMagnitude();
      testStepper();
      testFault();
      print_verdict();
   end
endmodule
`default_nettype wire
